/* rtl/fms_mode_seq.sv */
// Mode and frequency sequencer for an active-clamp flyback controller
// Contract
// - Discontinuous frequency never above half the resistor-set frequency.
// - Discontinuous frequency peaks at exit level, folds to skip level.
// - Below peak-freeze level keep a minimum on-time floor.
// - Frequency stops falling at 31 kHz, reached at the 400 mV skip level.
// - Restart a switching cycle once it has lasted 40 us.
// - Skip below skip level; resume above skip level plus hysteresis.
// - Clamp soft start widens pulses from 250 ns up to full off-time.
// - Leave clamped mode after feedback holds below exit level a while.
// - Soft stop narrows clamp pulses, folds frequency non-linearly to half.
// - Soft stop lasts 500 us.
// - Entry pin voltage quantized into bins selecting a fixed reference.
// - Fifteen entry references, 0.16 V apart, from 1.04 V to 3.28 V.
// - Entry pin source on from supply turn-on in all running modes.
// - Exit pin evaluated only after soft start and forced clamped time.
// - Exit pin source on after supply turn-on, off in discontinuous mode.
// - Soft start needs supply, line level, no fault, start delay done.
// - First 706 us of soft start run discontinuous to charge boot cap.
// - Soft start ramps the current-limit reference to its final value.
// - Then widen clamp pulses; clamped once current limit is maximum.
// - After start-up clamped entry, detection frozen twice soft start; code holds ST_SETTLE for twice the 706 us boot interval.
// - Boot interval ramps frequency up to half the resistor rate.
`timescale 1ns/1ps
module fms_mode_seq #(
    parameter int BOOT_CYC   = fms_pkg::BOOT_CYC_DEF,
    parameter int STOP_CYC   = fms_pkg::STOP_CYC_DEF,
    parameter int HOLD_CYC   = fms_pkg::HOLD_CYC_DEF,
    parameter int SETTLE_CYC = 2 * fms_pkg::BOOT_CYC_DEF
) (
    input  wire logic                         ref_clk,
    input  wire logic                         rst_b,
    input  wire logic                         clk_en,
    input  wire logic                         supply_on,
    input  wire logic                         hv_start_ok,
    input  wire logic                         fault_present,
    input  wire logic                         start_delay_done,
    input  wire logic                         pwm_trip,
    input  wire logic [fms_pkg::MV_W-1:0]     feedback_voltage,
    input  wire logic [fms_pkg::MV_W-1:0]     entry_threshold_pin,
    input  wire logic [fms_pkg::MV_W-1:0]     exit_threshold_pin,
    input  wire logic [15:0]                  freq_set_period,
    output logic                              main_gate_drive,
    output logic                              clamp_gate_drive,
    output logic                              entry_src_en,
    output logic                              exit_src_en,
    output logic                              peak_floor,
    output logic                              skip_active,
    output logic [fms_pkg::ILIM_W-1:0]        ilim_ref,
    output fms_pkg::fms_state_t               mode_state
);
    import fms_pkg::*;

    localparam int SYNC_W   = 5 + 3 * MV_W + 16;
    localparam int ILIM_DIV = ((2 * BOOT_CYC) / 255 < 1) ? 1
                              : (2 * BOOT_CYC) / 255;

    // Codes are sampled as a whole; they must move slowly against the clock
    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    wire  [SYNC_W-1:0] pins_w = {supply_on, hv_start_ok, fault_present,
                                 start_delay_done, pwm_trip,
                                 feedback_voltage, entry_threshold_pin,
                                 exit_threshold_pin, freq_set_period};

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else if (clk_en) begin
            sync1_ff <= pins_w;
            sync2_ff <= sync1_ff;
        end
    end

    wire             supply_s = sync2_ff[SYNC_W-1];
    wire             hv_s     = sync2_ff[SYNC_W-2];
    wire             fault_s  = sync2_ff[SYNC_W-3];
    wire             delay_s  = sync2_ff[SYNC_W-4];
    wire             trip_s   = sync2_ff[SYNC_W-5];
    wire [MV_W-1:0]  fb_s     = sync2_ff[16+3*MV_W-1 -: MV_W];
    wire [MV_W-1:0]  entry_s  = sync2_ff[16+2*MV_W-1 -: MV_W];
    wire [MV_W-1:0]  exit_s   = sync2_ff[16+MV_W-1 -: MV_W];
    wire [15:0]      rt_s     = sync2_ff[15:0];

    fms_state_t       state_ff;
    fms_state_t       nxt_state;
    logic [TMR_W-1:0] tmr_ff;
    logic [PER_W-1:0] cyc_cnt_ff;
    logic [PER_W-1:0] period_ff;
    logic [PER_W-1:0] nxt_period;
    logic [PER_W-1:0] last_on_ff;
    logic [15:0]      ilim_div_ff;
    logic             boot_path_ff;

    fms_lem_if lem ();

    fms_lem_seq u_lem (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .lem     (lem.seq)
    );

    // Resistor-set period, floored at the fastest legal oscillator rate
    wire [15:0]      rt_lim_w = (rt_s < RT_MIN_V) ? RT_MIN_V : rt_s;
    wire [16:0]      rt_dbl_w = {rt_lim_w, 1'b0};
    // half frequency is twice the period
    wire [PER_W-1:0] pmin_w   = (rt_dbl_w > 17'(CLAMP_PER_V)) ? CLAMP_PER_V
                                : rt_dbl_w[PER_W-1:0];
    wire [PER_W-1:0] acf_per_w = (rt_lim_w > 16'(CLAMP_PER_V)) ? CLAMP_PER_V
                                 : rt_lim_w[PER_W-1:0];
    wire [MV_W-1:0]  entry_ref_w = entry_ref(entry_s);
    // foldback slope set by exit level
    wire [PER_W-1:0] fold_w   = fold_period(fb_s, exit_s, pmin_w);

    wire is_dcm_w  = (state_ff == ST_DCM);
    wire is_acf_w  = (state_ff == ST_SETTLE) || (state_ff == ST_ACF) ||
                     (state_ff == ST_EXIT_WAIT);
    wire start_ok_w = supply_s && hv_s && !fault_s && delay_s;
    wire ilim_up_w  = (state_ff == ST_BOOT) || (state_ff == ST_CLAMP_SS);

    // cycle ends at period or 40 us limit
    wire cyc_end_w = (cyc_cnt_ff >= period_ff - 11'h001) ||
                     (cyc_cnt_ff >= CYC_LIM_V - 11'h001);
    // frozen floor keeps the on-time long enough
    wire trip_ok_w = trip_s && (!peak_floor || cyc_cnt_ff >= MIN_ON_CYC);
    wire on_end_w  = trip_ok_w ||
                     (cyc_cnt_ff >= period_ff - MIN_OFF_V - 11'h001);
    wire pulse_go_w = cyc_end_w && !skip_active && (state_ff != ST_OFF);
    wire [PER_W-1:0] left_w = period_ff - 11'h001 - cyc_cnt_ff;
    wire clamp_on_w = !main_gate_drive && !cyc_end_w &&
                      (lem.width != '0) && (left_w <= lem.width);
    wire nxt_main   = cyc_end_w ? pulse_go_w
                      : (main_gate_drive && !on_end_w);

    assign lem.cyc_start = cyc_end_w;
    assign lem.widen     = (state_ff == ST_CLAMP_SS);
    assign lem.shrink    = (state_ff == ST_SOFT_STOP);
    assign lem.full_mode = is_acf_w;
    assign lem.off_len   = period_ff - last_on_ff;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF: if (start_ok_w) begin
                nxt_state = ST_BOOT;
            end
            ST_BOOT: if (tmr_ff == TMR_W'(BOOT_CYC - 1)) begin
                nxt_state = ST_CLAMP_SS;
            end
            ST_CLAMP_SS: if (ilim_ref == ILIM_MAX && lem.at_full) begin
                nxt_state = boot_path_ff ? ST_SETTLE : ST_ACF;
            end
            ST_SETTLE: if (tmr_ff == TMR_W'(SETTLE_CYC - 1)) begin
                nxt_state = ST_ACF;
            end
            ST_ACF: if (fb_s < exit_s) begin
                nxt_state = ST_EXIT_WAIT;
            end
            // exit after hold interval below level
            ST_EXIT_WAIT: if (fb_s >= exit_s) begin
                nxt_state = ST_ACF;
            end else if (tmr_ff == TMR_W'(HOLD_CYC - 1)) begin
                nxt_state = ST_SOFT_STOP;
            end
            ST_SOFT_STOP: if (tmr_ff == TMR_W'(STOP_CYC - 1)) begin
                nxt_state = ST_DCM;
            end
            ST_DCM: if (fb_s > entry_ref_w) begin
                nxt_state = ST_CLAMP_SS;
            end
            default: nxt_state = ST_OFF;
        endcase
        if (!supply_s || fault_s) begin
            nxt_state = ST_OFF;
        end
    end

    // stepped ramps at cycle ends, direct otherwise
    always_comb begin
        nxt_period = period_ff;
        case (state_ff)
            ST_OFF:      nxt_period = CLAMP_PER_V;
            ST_DCM:      nxt_period = fold_w;
            ST_CLAMP_SS: nxt_period = acf_per_w;
            ST_BOOT: if (cyc_end_w) begin
                nxt_period = (period_ff > pmin_w + BOOT_STEP)
                             ? period_ff - BOOT_STEP : pmin_w;
            end
            ST_SOFT_STOP: if (cyc_end_w) begin
                nxt_period = (pmin_w > period_ff)
                    ? period_ff + ((pmin_w - period_ff) >> 2)
                    : period_ff - ((period_ff - pmin_w) >> 2);
            end
            default:     nxt_period = acf_per_w;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_ff <= ST_OFF;
            tmr_ff   <= '0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            tmr_ff   <= (nxt_state != state_ff) ? '0 : tmr_ff + 17'h00001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            boot_path_ff <= 1'b0;
        end else if (clk_en) begin
            if (state_ff == ST_BOOT) begin
                boot_path_ff <= 1'b1;
            end else if (state_ff == ST_SETTLE || state_ff == ST_OFF) begin
                boot_path_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cyc_cnt_ff      <= '0;
            period_ff       <= CLAMP_PER_V;
            last_on_ff      <= '0;
            main_gate_drive <= 1'b0;
            clamp_gate_drive <= 1'b0;
        end else if (clk_en) begin
            cyc_cnt_ff       <= cyc_end_w ? '0 : cyc_cnt_ff + 11'h001;
            period_ff        <= nxt_period;
            main_gate_drive  <= nxt_main;
            clamp_gate_drive <= clamp_on_w;
            if (main_gate_drive && !nxt_main) begin
                last_on_ff <= cyc_cnt_ff + 11'h001;
            end
        end
    end

    // current-limit reference ramps during soft start
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ilim_ref    <= '0;
            ilim_div_ff <= '0;
        end else if (clk_en) begin
            if (state_ff == ST_OFF) begin
                ilim_ref    <= '0;
                ilim_div_ff <= '0;
            end else if (ilim_up_w && ilim_ref != ILIM_MAX) begin
                if (ilim_div_ff == 16'(ILIM_DIV - 1)) begin
                    ilim_div_ff <= '0;
                    ilim_ref    <= ilim_ref + 8'h01;
                end else begin
                    ilim_div_ff <= ilim_div_ff + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            skip_active  <= 1'b0;
            peak_floor   <= 1'b0;
            entry_src_en <= 1'b0;
            exit_src_en  <= 1'b0;
            mode_state   <= ST_OFF;
        end else if (clk_en) begin
            if (!is_dcm_w) begin
                skip_active <= 1'b0;
            end else if (fb_s < SKIP_MV) begin
                skip_active <= 1'b1;
            end else if (fb_s > SKIP_MV + SKIP_HYS_MV) begin
                skip_active <= 1'b0;
            end
            peak_floor   <= is_dcm_w && (fb_s <= FREEZE_MV);
            entry_src_en <= supply_s;
            // exit source off in discontinuous mode
            exit_src_en  <= supply_s && (nxt_state != ST_BOOT) &&
                            (nxt_state != ST_DCM);
            mode_state   <= nxt_state;
        end
    end

    default clocking seq_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_start_req;
        state_ff == ST_OFF && start_ok_w && supply_s && !fault_s && clk_en;
    endsequence

    chk_start_gate: assert property (
        s_start_req |=> state_ff == ST_BOOT)
        else $error("soft start did not begin when allowed");
    chk_start_cause: assert property (
        state_ff == ST_BOOT && $past(state_ff) == ST_OFF |-> $past(start_ok_w))
        else $error("soft start began without all conditions");
    chk_dcm_period: assert property (
        is_dcm_w && $past(state_ff) == ST_DCM |-> period_ff >= pmin_w)
        else $error("discontinuous period below twice resistor period");
    chk_cycle_limit: assert property (
        cyc_cnt_ff < CYC_LIM_V && period_ff <= CLAMP_PER_V)
        else $error("switching cycle exceeded its limit");
    chk_skip_hold: assert property (
        skip_active && cyc_end_w && clk_en |=> !main_gate_drive)
        else $error("pulse issued while skipping");
    chk_skip_resume: assert property (
        $fell(skip_active) && $past(is_dcm_w) |->
        $past(fb_s) > SKIP_MV + SKIP_HYS_MV)
        else $error("skip left without hysteresis margin");
    chk_boot_no_clamp: assert property (
        state_ff == ST_BOOT |-> !clamp_gate_drive && !exit_src_en)
        else $error("clamp pulse or exit source during boot");
    chk_settle_lock: assert property (
        state_ff == ST_SETTLE && clk_en |=>
        state_ff inside {ST_SETTLE, ST_ACF, ST_OFF})
        else $error("mode changed during settle interval");
    chk_floor_on: assert property (
        main_gate_drive && !nxt_main && !cyc_end_w && peak_floor &&
        trip_s |-> cyc_cnt_ff >= MIN_ON_CYC)
        else $error("on-time ended below peak floor");
    chk_entry_src: assert property (
        state_ff != ST_OFF |-> entry_src_en)
        else $error("entry source off while running");

endmodule // fms_mode_seq

/* rtl/fms_pkg.sv */
// Shared constants, types and helper functions for the flyback mode sequencer
package fms_pkg;

    localparam int CLK_HZ      = 40_000_000;
    localparam int PER_W       = 11;
    localparam int MV_W        = 12;
    localparam int TMR_W       = 17;
    localparam int ILIM_W      = 8;

    // Figures in their own units, cycle counts derived from the clock rate
    localparam int MIN_FREQ_HZ = 31_000;
    localparam int CLAMP_PER   = CLK_HZ / MIN_FREQ_HZ;
    localparam int CYC_MAX_US  = 40;
    localparam int CYC_LIMIT   = CYC_MAX_US * (CLK_HZ / 1_000_000);
    localparam int LEM_MIN_NS  = 250;
    localparam int LEM_MIN_CYC = (LEM_MIN_NS * (CLK_HZ / 1_000_000) + 999)
                                 / 1000;
    localparam int MIN_OFF_NS  = 590;
    localparam int MIN_OFF_CYC = (MIN_OFF_NS * (CLK_HZ / 1_000_000) + 999)
                                 / 1000;
    localparam int BOOT_US     = 706;
    localparam int BOOT_CYC_DEF = BOOT_US * (CLK_HZ / 1_000_000);
    localparam int STOP_US     = 500;
    localparam int STOP_CYC_DEF = STOP_US * (CLK_HZ / 1_000_000);
    localparam int HOLD_US     = 100;
    localparam int HOLD_CYC_DEF = HOLD_US * (CLK_HZ / 1_000_000);
    localparam int RT_MIN_CYC  = 40;

    localparam logic [PER_W-1:0] CLAMP_PER_V = PER_W'(CLAMP_PER);
    localparam logic [PER_W-1:0] CYC_LIM_V   = PER_W'(CYC_LIMIT);
    localparam logic [PER_W-1:0] LEM_MIN_W   = PER_W'(LEM_MIN_CYC);
    localparam logic [PER_W-1:0] MIN_OFF_V   = PER_W'(MIN_OFF_CYC);
    localparam logic [PER_W-1:0] LEM_STEP    = 11'h001;
    localparam logic [PER_W-1:0] BOOT_STEP   = 11'h020;
    localparam logic [PER_W-1:0] MIN_ON_CYC  = 11'h014;
    localparam logic [15:0]      RT_MIN_V    = 16'(RT_MIN_CYC);

    // Feedback levels in millivolts
    localparam logic [MV_W-1:0] SKIP_MV     = 12'h190;
    localparam logic [MV_W-1:0] SKIP_HYS_MV = 12'h032;
    localparam logic [MV_W-1:0] FREEZE_MV   = 12'h320;

    // Entry references: base plus step per bin; bins split at midpoints
    localparam int              ENTRY_BINS = 15;
    localparam logic [MV_W-1:0] ENTRY_BASE = 12'h410;
    localparam logic [MV_W-1:0] ENTRY_STEP = 12'h0a0;
    localparam logic [MV_W-1:0] ENTRY_MID [ENTRY_BINS] = '{
        12'h000, 12'h083, 12'h0c9, 12'h0f7, 12'h12e,
        12'h169, 12'h1ac, 12'h1f3, 12'h247, 12'h2b2,
        12'h326, 12'h3af, 12'h44d, 12'h508, 12'h5e0};

    localparam logic [ILIM_W-1:0] ILIM_MAX = 8'hff;

    typedef enum logic [2:0] {
        ST_OFF       = 3'h0,
        ST_BOOT      = 3'h1,
        ST_CLAMP_SS  = 3'h2,
        ST_SETTLE    = 3'h3,
        ST_ACF       = 3'h4,
        ST_EXIT_WAIT = 3'h5,
        ST_SOFT_STOP = 3'h6,
        ST_DCM       = 3'h7
    } fms_state_t;

    function automatic logic [MV_W-1:0] entry_ref(input logic [MV_W-1:0] pin);
        logic [3:0] idx;
        idx = 4'h0;
        for (int k = 1; k < ENTRY_BINS; k++) begin
            if (pin >= ENTRY_MID[k]) begin
                idx = 4'(k);
            end
        end
        entry_ref = ENTRY_BASE + 12'(idx) * ENTRY_STEP;
    endfunction

    // Period stretches linearly from pmin at the exit level to the clamp
    function automatic logic [PER_W-1:0] fold_period(
        input logic [MV_W-1:0]  fb,
        input logic [MV_W-1:0]  thr,
        input logic [PER_W-1:0] pmin);
        logic [23:0] num;
        logic [23:0] q;
        num = '0;
        q   = '0;
        if (fb >= thr || thr <= SKIP_MV) begin
            fold_period = pmin;
        end else if (fb <= SKIP_MV) begin
            fold_period = CLAMP_PER_V;
        end else begin
            num = 24'(CLAMP_PER_V - pmin) * 24'(thr - fb);
            q   = num / 24'(thr - SKIP_MV);
            fold_period = pmin + q[PER_W-1:0];
        end
    endfunction

endpackage

/* rtl/fms_lem_if.sv */
// Carrier between the mode engine and the clamp pulse-width sequencer
`timescale 1ns/1ps
interface fms_lem_if;
    logic                       cyc_start;
    logic                       widen;
    logic                       shrink;
    logic                       full_mode;
    logic [fms_pkg::PER_W-1:0]  off_len;
    logic [fms_pkg::PER_W-1:0]  width;
    logic                       at_full;

    modport seq (input cyc_start, input widen, input shrink,
                 input full_mode, input off_len,
                 output width, output at_full);
    modport ctl (output cyc_start, output widen, output shrink,
                 output full_mode, output off_len,
                 input width, input at_full);
endinterface

/* rtl/fms_lem_seq.sv */
// Clamp pulse-width sequencer for leading-edge soft start and soft stop
`timescale 1ns/1ps
module fms_lem_seq (
    input  wire logic   ref_clk,
    input  wire logic   rst_b,
    input  wire logic   clk_en,
    fms_lem_if.seq      lem
);
    import fms_pkg::*;

    logic [PER_W-1:0] width_ff;
    logic [PER_W-1:0] nxt_width;

    wire [PER_W-1:0] grown_w = (width_ff == '0) ? LEM_MIN_W
                                                : width_ff + LEM_STEP;
    wire [PER_W-1:0] grow_w  = (grown_w > lem.off_len) ? lem.off_len
                                                       : grown_w;
    wire [PER_W-1:0] cut_w   = (width_ff <= LEM_MIN_W) ? '0
                                                       : width_ff - LEM_STEP;

    assign lem.width   = width_ff;
    assign lem.at_full = (width_ff >= lem.off_len);

    always_comb begin
        nxt_width = width_ff;
        if (lem.cyc_start) begin
            if (lem.full_mode) begin
                nxt_width = lem.off_len;
            end else if (lem.widen) begin
                nxt_width = grow_w;
            end else if (lem.shrink) begin
                nxt_width = cut_w;
            end else begin
                nxt_width = '0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            width_ff <= '0;
        end else if (clk_en) begin
            width_ff <= nxt_width;
        end
    end

    default clocking lem_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    chk_lem_first_pulse: assert property (
        clk_en && lem.cyc_start && lem.widen && !lem.full_mode &&
        width_ff == '0 && lem.off_len >= LEM_MIN_W |=> width_ff == LEM_MIN_W)
        else $error("clamp soft start did not begin at minimum width");

    chk_lem_grow_step: assert property (
        clk_en && lem.cyc_start && lem.widen && !lem.full_mode &&
        width_ff != '0 |=> width_ff <= $past(width_ff) + LEM_STEP)
        else $error("clamp width grew by more than one step");

    chk_lem_shrink: assert property (
        clk_en && lem.cyc_start && lem.shrink && !lem.full_mode &&
        !lem.widen && width_ff != '0 |=> width_ff < $past(width_ff))
        else $error("clamp width did not narrow during soft stop");

endmodule // fms_lem_seq

/* tb/fms_stage_model.sv */
// Power stage stand-in that ends each main on-time with a current trip
`timescale 1ns/1ps
module fms_stage_model #(
    parameter int TRIP_CYC = 30
) (
    input  wire logic ref_clk,
    input  wire logic main_gate_drive,
    output logic      pwm_trip
);
    int on_cnt = 0;
    always_ff @(posedge ref_clk) begin
        on_cnt <= main_gate_drive ? on_cnt + 1 : 0;
    end
    // Trip line reads low once the main switch is off, never stale
    assign pwm_trip = main_gate_drive && (on_cnt >= TRIP_CYC);
endmodule // fms_stage_model

/* tb/flyback_mode_sequencer_test.sv */
// Self-checking bench for the flyback mode sequencer
`timescale 1ns/1ps
module flyback_mode_sequencer_test;
    import fms_pkg::*;
    localparam int RT = 100;
    logic            ref_clk = 0, rst_b = 0, fault = 1, trip;
    logic            supply = 1, hv = 0, dly = 0;
    logic [MV_W-1:0] fb = 12'hfff, ent = 12'h000, ext = 12'h258, r;
    logic            main_g, clamp_g, ent_en, ext_en, pk, skip;
    logic [7:0]      ilim;
    fms_state_t      st;
    int              fail_count = 0, checks_done = 0, n, w;
    logic [31:0]     lfsr = 32'h5c686932;
    always #12.5 ref_clk = ~ref_clk;
    fms_stage_model stage (.ref_clk(ref_clk), .main_gate_drive(main_g),
        .pwm_trip(trip));
    fms_mode_seq #(.BOOT_CYC(200), .STOP_CYC(300), .HOLD_CYC(50),
        .SETTLE_CYC(400)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .clk_en(1'b1), .supply_on(supply), .hv_start_ok(hv),
        .fault_present(fault), .start_delay_done(dly), .pwm_trip(trip),
        .feedback_voltage(fb), .entry_threshold_pin(ent),
        .exit_threshold_pin(ext), .freq_set_period(16'(RT)),
        .main_gate_drive(main_g), .clamp_gate_drive(clamp_g),
        .entry_src_en(ent_en), .exit_src_en(ext_en), .peak_floor(pk),
        .skip_active(skip), .ilim_ref(ilim), .mode_state(st));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Bin by midpoint, reference 1.04 V plus 0.16 V per bin
    function automatic logic [MV_W-1:0] ref_of(input logic [MV_W-1:0] p);
        int b = 0;
        for (int k = 1; k < ENTRY_BINS; k++) if (p >= ENTRY_MID[k]) b = k;
        return 12'(1040 + 160 * b);
    endfunction
    task automatic step(input int c);
        repeat (c) @(posedge ref_clk);
        #2;
    endtask
    task automatic conclude;
        $display("fail_count %0d checks_done %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_st(input fms_state_t s, input int lim);
        for (n = 0; st !== s && n < lim; n++) step(1);
        if (st !== s) begin
            chk(16'(st), 16'(s));
            conclude();
        end
    endtask
    // Counts cycles while the main drive holds level v
    task automatic hold(input logic v);
        int k;
        for (k = 0; main_g === v && k < 4000; k++) begin
            step(1);
            n++;
        end
        if (k >= 4000) chk(16'(k), 16'h0);
        if (k >= 4000) conclude();
    endtask
    // Waits for the next clamp pulse and measures its length in cycles
    task automatic clamp_len(output int len);
        int k;
        for (k = 0; clamp_g !== 1'b1 && k < 4000; k++) step(1);
        for (len = 0; clamp_g === 1'b1 && len < 4000; len++) step(1);
        if (k >= 4000 || len >= 4000) begin
            chk(16'(k + len), 16'h0);
            conclude();
        end
    endtask
    initial begin
        step(16);
        rst_b = 1;
        step(20);
        chk(16'(st), 16'(ST_OFF));
        chk({ent_en, ext_en}, 2'h3);
        fault = 0;
        step(10);
        chk(16'(st), 16'(ST_OFF));
        hv = 1;
        step(10);
        chk(16'(st), 16'(ST_OFF));
        dly = 1;
        wait_st(ST_BOOT, 10);
        chk(ent_en, 1);
        chk(ext_en, 0);
        wait_st(ST_CLAMP_SS, 400);
        chk(n >= 195, 1);
        wait_st(ST_SETTLE, 40000);
        chk(ilim, ILIM_MAX);
        wait_st(ST_ACF, 600);
        chk(n >= 395, 1);
        chk(ext_en, 1);
        for (int i = 0; i < 3; i++) begin
            fb = 12'h1f4;
            wait_st(ST_EXIT_WAIT, 10);
            wait_st(ST_SOFT_STOP, 100);
            chk(n >= 48, 1);
            wait_st(ST_DCM, 400);
            chk(n >= 295, 1);
            step(1);
            chk({ext_en, ent_en, pk}, 3'h3);
            hold(1);
            hold(0);
            n = 0;
            hold(1);
            hold(0);
            chk(n >= 2 * RT && n <= CLAMP_PER + 2, 1);
            fb = 12'h15e;
            step(10);
            chk(skip, 1);
            fb = 12'h1a4;
            step(10);
            chk(skip, 1);
            fb = 12'h1d6;
            step(10);
            chk(skip, 0);
            lfsr = nxt(lfsr);
            ent = (i == 0) ? 12'h000 : (i == 1) ? 12'h5e0 : 12'(lfsr % 1700);
            r = ref_of(ent);
            fb = r - 12'h014;
            step(40);
            chk(16'(st), 16'(ST_DCM));
            fb = r + 12'h014;
            wait_st(ST_CLAMP_SS, 10);
            clamp_len(w);
            chk(16'(w), 16'(LEM_MIN_CYC));
            clamp_len(w);
            chk(16'(w), 16'(LEM_MIN_CYC + 1));
            wait_st(ST_ACF, 40000);
        end
        supply = 0;
        wait_st(ST_OFF, 10);
        chk({ent_en, ext_en}, 2'h0);
        conclude();
    end
endmodule // flyback_mode_sequencer_test
